// ===== design/rod_cfg.svh
// register offsets, field positions and persistence counts for the overhead drop bank
// assumes a 32-bit register port decoded on a 12-bit byte address
`ifndef ROD_CFG_SVH
`define ROD_CFG_SVH
`define ROD_OFS_DCC_MID 12'h374
`define ROD_OFS_DCC_UP 12'h378
`define ROD_OFS_SGO 12'h37C
`define ROD_OFS_GF6 12'h380
`define ROD_OFS_GF12 12'h384
`define ROD_OFS_J1 12'h388
`define ROD_OFS_C2 12'h38C
`define ROD_OFS_PSU 12'h390
`define ROD_OFS_PGR 12'h394
`define ROD_RESET_VAL 32'h0000_0000
`define ROD_GF6_FRAMES 4'h6
`define ROD_GF12_FRAMES 4'hC
`define ROD_GF6_LO 1
`define ROD_GF6_HI 2
`define ROD_GF12_LO 0
`define ROD_GF12_HI 1
`define ROD_C2_FRAMES_3 4'h3
`define ROD_C2_FRAMES_5 4'h5
`endif

// ===== design/rod_pkg.sv
// types for the receive overhead drop bank
// assumes rod_cfg.svh is compiled alongside
package rod_pkg;
  typedef struct packed {
    logic [7:0] d7; logic [7:0] d8; logic [7:0] d9;
    logic [7:0] d10; logic [7:0] d11; logic [7:0] d12;
    logic [7:0] s1; logic [7:0] z2; logic [7:0] e2;
    logic [7:0] j1; logic [7:0] c2;
    logic [7:0] g1; logic [7:0] f2; logic [7:0] h4;
    logic [7:0] z3; logic [7:0] z4; logic [7:0] z5;
  } rod_oh_t;
endpackage : rod_pkg

// ===== design/rod_bank.sv
// receive overhead drop registers for one port
// assumes oh_valid pulses once per frame, in clk domain, when all oh bytes are final
`include "rod_cfg.svh"
module rod_bank
  import rod_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic oh_valid,
  input wire rod_oh_t oh_bytes,
  input wire logic c2_five,
  input wire logic [11:0] rd_addr,
  output logic [31:0] rd_data
);

  rod_oh_t cap_r;
  logic [7:0] gf6_r, gf12_r, c2_r;
  logic [7:0] gf6_cand_r, gf12_cand_r, c2_cand_r;
  logic [3:0] gf6_cnt_r, gf12_cnt_r, c2_cnt_r;
  logic [31:0] rd_nxt;

  function automatic logic [31:0] pack3(input logic [7:0] lo, input logic [7:0] mid,
                                        input logic [7:0] hi);
    pack3 = {8'h00, hi, mid, lo};
  endfunction : pack3

  // persistence step: count a run of equal candidates, restart on a change
  function automatic logic [3:0] run_cnt(input logic same, input logic [3:0] cnt,
                                         input logic [3:0] lim);
    if (!same)
      run_cnt = 4'h1;
    else if (cnt < lim)
      run_cnt = cnt + 4'h1;
    else
      run_cnt = cnt;
  endfunction : run_cnt

  // compared field bits; bit numbering 1..8 from msb maps 6-7 to [2:1], 7-8 to [1:0]
  wire logic [1:0] z2_f6 = oh_bytes.z2[2:1];
  wire logic [1:0] z2_f12 = oh_bytes.z2[1:0];
  wire logic gf6_same = (z2_f6 == gf6_cand_r[2:1]);
  wire logic gf12_same = (z2_f12 == gf12_cand_r[1:0]);
  wire logic c2_same = (oh_bytes.c2 == c2_cand_r);
  wire logic [3:0] c2_lim = c2_five ? `ROD_C2_FRAMES_5 : `ROD_C2_FRAMES_3;
  wire logic [3:0] gf6_cnt_nxt = run_cnt(gf6_same, gf6_cnt_r, `ROD_GF6_FRAMES);
  wire logic [3:0] gf12_cnt_nxt = run_cnt(gf12_same, gf12_cnt_r, `ROD_GF12_FRAMES);
  wire logic [3:0] c2_cnt_nxt = run_cnt(c2_same, c2_cnt_r, c2_lim);
  // once a run reaches the limit the register follows; counts restart on change
  wire logic gf6_upd = oh_valid && gf6_cnt_nxt == `ROD_GF6_FRAMES
                       && oh_bytes.z2 != gf6_r;
  wire logic gf12_upd = oh_valid && gf12_cnt_nxt == `ROD_GF12_FRAMES
                        && oh_bytes.z2 != gf12_r;
  wire logic c2_upd = oh_valid && c2_cnt_nxt == c2_lim && oh_bytes.c2 != c2_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_r <= '0;
    else if (oh_valid)
      cap_r <= oh_bytes;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gf6_cand_r <= 8'h00;
      gf6_cnt_r <= 4'h0;
      gf6_r <= 8'h00;
    end
    else if (oh_valid)
    begin
      gf6_cand_r <= oh_bytes.z2;
      gf6_cnt_r <= gf6_upd ? 4'h0 : gf6_cnt_nxt;
      if (gf6_upd)
        gf6_r <= oh_bytes.z2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gf12_cand_r <= 8'h00;
      gf12_cnt_r <= 4'h0;
      gf12_r <= 8'h00;
    end
    else if (oh_valid)
    begin
      gf12_cand_r <= oh_bytes.z2;
      gf12_cnt_r <= gf12_upd ? 4'h0 : gf12_cnt_nxt;
      if (gf12_upd)
        gf12_r <= oh_bytes.z2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c2_cand_r <= 8'h00;
      c2_cnt_r <= 4'h0;
      c2_r <= 8'h00;
    end
    else if (oh_valid)
    begin
      c2_cand_r <= oh_bytes.c2;
      c2_cnt_r <= c2_upd ? 4'h0 : c2_cnt_nxt;
      if (c2_upd)
        c2_r <= oh_bytes.c2;
    end
  end

  // read mux is pure decode; nothing changes state on a read
  always_comb
  begin
    unique case (rd_addr)
      `ROD_OFS_DCC_MID: rd_nxt = pack3(cap_r.d7, cap_r.d8, cap_r.d9);
      `ROD_OFS_DCC_UP: rd_nxt = pack3(cap_r.d10, cap_r.d11, cap_r.d12);
      `ROD_OFS_SGO: rd_nxt = pack3(cap_r.s1, cap_r.z2, cap_r.e2);
      `ROD_OFS_GF6: rd_nxt = {24'h000000, gf6_r};
      `ROD_OFS_GF12: rd_nxt = {24'h000000, gf12_r};
      `ROD_OFS_J1: rd_nxt = {24'h000000, cap_r.j1};
      `ROD_OFS_C2: rd_nxt = {24'h000000, c2_r};
      `ROD_OFS_PSU: rd_nxt = pack3(cap_r.g1, cap_r.f2, cap_r.h4);
      `ROD_OFS_PGR: rd_nxt = pack3(cap_r.z3, cap_r.z4, cap_r.z5);
      default: rd_nxt = `ROD_RESET_VAL;
    endcase
  end

  // registered read keeps the output straight from a flop, one cycle latency
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= `ROD_RESET_VAL;
    else
      rd_data <= rd_nxt;
  end

  sequence six_equal_s;
    oh_valid && gf6_cnt_nxt == 4'h6;
  endsequence

  sequence twelve_equal_s;
    oh_valid && gf12_cnt_nxt == 4'hC;
  endsequence

  // limit follows c2_five in the same cycle as the frame strobe
  sequence c2_run_done_s;
    oh_valid && c2_cnt_nxt == c2_lim;
  endsequence

  frame_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    oh_valid |=> cap_r == $past(oh_bytes)) else $error("frame bytes not captured");
  dcc_mid_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h374 |=> rd_data == {8'h00, $past(cap_r.d9), $past(cap_r.d8),
    $past(cap_r.d7)}) else $error("middle dcc read wrong");
  dcc_up_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h378 |=> rd_data[23:16] == $past(cap_r.d12)) else $error("d12 lane wrong");
  sgo_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h37C |=> rd_data[15:8] == $past(cap_r.z2)) else $error("z2 lane wrong");
  gf6_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(gf6_r) |-> $past(gf6_cnt_nxt) == 4'h6) else $error("six copy early");
  gf6_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    six_equal_s ##0 (oh_bytes.z2 != gf6_r) |=> gf6_r == $past(oh_bytes.z2))
    else $error("six copy missed");
  gf12_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(gf12_r) |-> $past(gf12_cnt_nxt) == 4'hC) else $error("twelve copy early");
  gf12_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    twelve_equal_s ##0 (oh_bytes.z2 != gf12_r) |=> gf12_r == $past(oh_bytes.z2))
    else $error("twelve copy missed");
  j1_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h388 |=> rd_data == {24'h0, $past(cap_r.j1)}) else $error("j1 read wrong");
  c2_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(c2_r) |-> $past(c2_cnt_nxt) == ($past(c2_five) ? 4'h5 : 4'h3))
    else $error("c2 changed early");
  c2_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    c2_run_done_s ##0 (oh_bytes.c2 != c2_r) |=> c2_r == $past(oh_bytes.c2))
    else $error("c2 label missed");
  psu_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h390 |=> rd_data[7:0] == $past(cap_r.g1)) else $error("g1 lane wrong");
  pgr_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h394 |=> rd_data[23:16] == $past(cap_r.z5)) else $error("z5 lane wrong");
  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_addr == 12'h000 |=> rd_data == 32'h0) else $error("unmapped not zero");

endmodule : rod_bank

// ===== dv/rod_frame_src.sv
// far-end transmitter model: one strobed frame of overhead bytes
// assumes the bench clock; bytes go stale (inverted) between frames
module rod_frame_src
  import rod_pkg::*;
(
  input wire logic clk,
  output logic oh_valid,
  output rod_oh_t oh_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    oh_valid = 1'b0;
    oh_bytes = '0;
  end
  // stale bytes inverted so a late sample cannot pass by luck
  task automatic send(input rod_oh_t f);
    @(posedge clk);
    #1;
    oh_valid = 1'b1;
    oh_bytes = f;
    @(posedge clk);
    #1;
    oh_valid = 1'b0;
    oh_bytes = ~f;
  endtask : send
endmodule : rod_frame_src

// ===== dv/rx_overhead_drop_registers_test.sv
// self-checking bench for the overhead drop bank
// assumes rod_bank and rod_frame_src; inputs move 1 ns after the edge
`include "rod_cfg.svh"
module rx_overhead_drop_registers_test
  import rod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic oh_valid;
  rod_oh_t oh_bytes;
  logic c2_five = 1'b0;
  logic [11:0] rd_addr = 12'h000;
  logic [31:0] rd_data;
  int err_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  rod_frame_src u_rod_frame_src (.clk(clk), .oh_valid(oh_valid), .oh_bytes(oh_bytes));
  rod_bank u_rod_bank (.clk(clk), .rst_n(rst_n), .oh_valid(oh_valid), .oh_bytes(oh_bytes),
    .c2_five(c2_five), .rd_addr(rd_addr), .rd_data(rd_data));
  task automatic complete_run();
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // read data is registered: look one edge after the address
  task automatic chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    #1;
    rd_addr = a;
    @(posedge clk);
    #1;
    total_checks++;
    if (rd_data !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t addr %h got %h exp %h", $time, a, rd_data, exp);
    end
  endtask : chk
  function automatic rod_oh_t mk(input logic [7:0] b, input logic [7:0] z, input logic [7:0] c);
    rod_oh_t f;
    for (int i = 0; i < 17; i++)
      f[8*i +: 8] = b + 8'(i);
    f.z2 = z;
    f.c2 = c;
    return f;
  endfunction : mk
  // last step of the sweep lands on an unmapped word
  task automatic check_reset();
    for (int k = 0; k < 10; k++)
      chk(`ROD_OFS_DCC_MID + 12'(4 * k), `ROD_RESET_VAL);
  endtask : check_reset
  task automatic check_every_frame(input logic [7:0] b);
    rod_oh_t f;
    f = mk(b, 8'h5A, 8'hC3);
    u_rod_frame_src.send(f);
    chk(`ROD_OFS_DCC_MID, {8'h00, f.d9, f.d8, f.d7});
    chk(`ROD_OFS_DCC_UP, {8'h00, f.d12, f.d11, f.d10});
    chk(`ROD_OFS_SGO, {8'h00, f.e2, f.z2, f.s1});
    chk(`ROD_OFS_J1, {24'h000000, f.j1});
    chk(`ROD_OFS_PSU, {8'h00, f.h4, f.f2, f.g1});
    chk(`ROD_OFS_PGR, {8'h00, f.z5, f.z4, f.z3});
    chk(`ROD_OFS_PGR, {8'h00, f.z5, f.z4, f.z3});
  endtask : check_every_frame
  task automatic check_filters();
    for (int n = 1; n <= 12; n++)
    begin
      u_rod_frame_src.send(mk(8'(16 * n), 8'h07, 8'h13));
      if (n == 2) chk(`ROD_OFS_C2, 32'h0000_0000);
      if (n == 3) chk(`ROD_OFS_C2, 32'h0000_0013);
      if (n == 5) chk(`ROD_OFS_GF6, 32'h0000_0000);
      if (n == 6) chk(`ROD_OFS_GF6, 32'h0000_0007);
      if (n == 11) chk(`ROD_OFS_GF12, 32'h0000_0000);
      if (n == 12) chk(`ROD_OFS_GF12, 32'h0000_0007);
    end
    c2_five = 1'b1;
    for (int n = 1; n <= 5; n++)
    begin
      u_rod_frame_src.send(mk(8'h30, 8'h07, 8'hAA));
      if (n == 4) chk(`ROD_OFS_C2, 32'h0000_0013);
      if (n == 5) chk(`ROD_OFS_C2, 32'h0000_00AA);
    end
  endtask : check_filters
  // one odd frame in mid-run must restart the six-frame count
  task automatic check_run_break();
    for (int n = 0; n < 12; n++)
    begin
      u_rod_frame_src.send(mk(8'h20, (n == 5) ? 8'h07 : 8'h01, 8'hAA));
      if (n == 10) chk(`ROD_OFS_GF6, 32'h0000_0007);
      if (n == 11) chk(`ROD_OFS_GF6, 32'h0000_0001);
    end
  endtask : check_run_break
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check_reset();
    check_every_frame(8'h40);
    check_every_frame(8'h80);
    check_filters();
    check_run_break();
    complete_run();
  end
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule : rx_overhead_drop_registers_test
